// >>> core/debug_capture_if.sv
`timescale 1ns/10ps
interface debug_capture_if;
  logic [3:0] trigger_sel;
  logic flush;
  logic pop;
  logic [3:0] link_state;
  logic [31:0] data_out;
  logic empty;
  modport ctrl(output trigger_sel, output flush, output pop,
    output link_state, input data_out, input empty);
  modport store(input trigger_sel, input flush, input pop,
    input link_state, output data_out, output empty);
endinterface

// >>> core/switch_debug_pkg.sv
package switch_debug_pkg;
  localparam logic [7:0] OFS_MODE_CLKBUF = 8'h98;
  localparam logic [7:0] OFS_DEBUG_CTRL = 8'h9C;
  localparam logic [7:0] OFS_DEBUG_DATA = 8'hAC;
  localparam logic [7:0] OFS_CAP_HDR = 8'hB0;
  localparam logic [7:0] OFS_SUBSYS_ID = 8'hB4;
  localparam int MODE_W = 9;
  localparam logic [15:0] MODE_RESET = 16'h0122;
  localparam int CLOCK_BUFFER_POWERDOWN_STRAP_BIT = 20;
  localparam int CLKBUF_EN_LSB = 16;
  localparam logic [3:0] CLKBUF_EN_RESET = 4'hF;
  localparam int DBG_PORT_LSB = 0;
  localparam logic [1:0] DBG_PORT_RESET = 2'h0;
  localparam int TRIG_LSB = 2;
  localparam logic [3:0] TRIG_RESET = 4'h0;
  localparam logic [3:0] TRIG_FIRST = 4'h1;
  localparam logic [3:0] TRIG_LAST = 4'hB;
  localparam int CLEAR_BIT = 6;
  localparam logic CLEAR_RESET = 1'h0;
  localparam logic [7:0] CAP_ID = 8'h0D;
  localparam logic [7:0] NEXT_PTR = 8'hC0;
  localparam int STAMP_W = 28;
endpackage

// >>> core/switch_mode_debug_subsystem_regs.sv
`timescale 1ns/10ps
module switch_mode_debug_subsystem_regs #(
  parameter logic [15:0] VENDOR_DEFAULT = 16'h1A2B, // arbitrary value
  parameter logic [15:0] DEVICE_DEFAULT = 16'h3C4D, // arbitrary value
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clock_buffer_powerdown_strap,
  input wire logic [8:0] op_mode_pins,
  input wire logic [15:0] training_state_all,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic smb_req,
  input wire logic smb_we,
  input wire logic [7:0] smb_addr,
  input wire logic [31:0] smb_wdata,
  output logic smb_ack,
  output logic [31:0] smb_rdata,
  output logic [3:0] refclk_output_pair_en
);
  debug_capture_if dbg();

  logic strap_s1, strap_s2;
  logic [8:0] mode_s1, mode_s2;
  logic [15:0] mode_reg, mode_next;
  logic pd_reg, pd_next;
  logic [3:0] en_reg, en_next;
  logic [1:0] port_reg, port_next;
  logic [3:0] trig_reg, trig_next;
  logic clear_reg, clear_next;
  logic flush_reg, flush_next;
  logic [15:0] vendor_reg, vendor_next, device_reg, device_next;
  logic [3:0] refclk_next;
  logic cfg_ack_next, smb_ack_next;
  logic [31:0] cfg_rdata_next, smb_rdata_next;
  logic cfg_wr, smb_wr, smb_rd;

  assign cfg_wr = cfg_req && cfg_we;
  assign smb_wr = smb_req && smb_we; // also carries the EEPROM auto-load
  assign smb_rd = smb_req && !smb_we;

  training_capture_buffer #(.DEPTH(DEPTH), .AW(AW)) u_capture (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .dbg(dbg)
  );

  assign dbg.trigger_sel = trig_reg;
  assign dbg.flush = flush_reg;
  assign dbg.pop = smb_rd && smb_addr == switch_debug_pkg::OFS_DEBUG_DATA;
  assign dbg.link_state = training_state_all[{port_reg, 2'h0} +: 4];

  function automatic logic [31:0] read_word(input logic [7:0] a,
      input logic from_smb);
    case (a)
      switch_debug_pkg::OFS_MODE_CLKBUF:
        read_word = {11'h0, pd_reg, en_reg, mode_reg};
      switch_debug_pkg::OFS_DEBUG_CTRL:
        read_word = {25'h0, clear_reg, trig_reg, port_reg};
      switch_debug_pkg::OFS_DEBUG_DATA:
        read_word = from_smb ? dbg.data_out : 32'h00000000;
      switch_debug_pkg::OFS_CAP_HDR:
        read_word = {16'h0000, switch_debug_pkg::NEXT_PTR,
          switch_debug_pkg::CAP_ID};
      switch_debug_pkg::OFS_SUBSYS_ID:
        read_word = {device_reg, vendor_reg};
      default:
        read_word = 32'h00000000;
    endcase
  endfunction

  // pins cross in through two flops before anything reads them
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      strap_s1 <= clock_buffer_powerdown_strap;
      strap_s2 <= strap_s1;
      mode_s1 <= op_mode_pins;
      mode_s2 <= mode_s1;
    end
  end

  always_comb begin
    mode_next = {7'h0, mode_s2};
    pd_next = pd_reg;
    en_next = en_reg;
    port_next = port_reg;
    trig_next = trig_reg;
    clear_next = clear_reg;
    vendor_next = vendor_reg;
    device_next = device_reg;
    flush_next = 1'b0;
    // config writes to the clock buffer and ids are ignored
    if (cfg_wr && cfg_addr == switch_debug_pkg::OFS_DEBUG_CTRL) begin
      port_next = cfg_wdata[switch_debug_pkg::DBG_PORT_LSB +: 2];
      trig_next = cfg_wdata[switch_debug_pkg::TRIG_LSB +: 4];
      clear_next = cfg_wdata[switch_debug_pkg::CLEAR_BIT];
      flush_next = cfg_wdata[switch_debug_pkg::CLEAR_BIT];
    end
    // SMBus comes last so it wins a same-cycle collision; only the flush pulse takes the OR of both clears
    if (smb_wr) begin
      case (smb_addr)
        switch_debug_pkg::OFS_MODE_CLKBUF: begin
          pd_next = smb_wdata[switch_debug_pkg::CLOCK_BUFFER_POWERDOWN_STRAP_BIT];
          en_next = smb_wdata[switch_debug_pkg::CLKBUF_EN_LSB +: 4];
        end
        switch_debug_pkg::OFS_DEBUG_CTRL: begin
          port_next = smb_wdata[switch_debug_pkg::DBG_PORT_LSB +: 2];
          trig_next = smb_wdata[switch_debug_pkg::TRIG_LSB +: 4];
          clear_next = smb_wdata[switch_debug_pkg::CLEAR_BIT];
          flush_next = smb_wdata[switch_debug_pkg::CLEAR_BIT] || flush_next;
        end
        switch_debug_pkg::OFS_SUBSYS_ID: begin
          vendor_next = smb_wdata[15:0];
          device_next = smb_wdata[31:16];
        end
        default: begin
        end
      endcase
    end
    refclk_next = pd_reg ? 4'h0 : en_reg;
    cfg_ack_next = cfg_req;
    smb_ack_next = smb_req;
    cfg_rdata_next = (cfg_req && !cfg_we) ?
      read_word(cfg_addr, 1'b0) : cfg_rdata;
    smb_rdata_next = smb_rd ? read_word(smb_addr, 1'b1) : smb_rdata;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_reg <= switch_debug_pkg::MODE_RESET;
      pd_reg <= strap_s2;
      en_reg <= switch_debug_pkg::CLKBUF_EN_RESET;
      port_reg <= switch_debug_pkg::DBG_PORT_RESET;
      trig_reg <= switch_debug_pkg::TRIG_RESET;
      clear_reg <= switch_debug_pkg::CLEAR_RESET;
      flush_reg <= 1'b0;
      vendor_reg <= VENDOR_DEFAULT;
      device_reg <= DEVICE_DEFAULT;
      refclk_output_pair_en <= 4'h0;
      cfg_ack <= 1'b0;
      smb_ack <= 1'b0;
      cfg_rdata <= 32'h00000000;
      smb_rdata <= 32'h00000000;
    end else if (ce) begin
      mode_reg <= mode_next;
      pd_reg <= pd_next;
      en_reg <= en_next;
      port_reg <= port_next;
      trig_reg <= trig_next;
      clear_reg <= clear_next;
      flush_reg <= flush_next;
      vendor_reg <= vendor_next;
      device_reg <= device_next;
      refclk_output_pair_en <= refclk_next;
      cfg_ack <= cfg_ack_next;
      smb_ack <= smb_ack_next;
      cfg_rdata <= cfg_rdata_next;
      smb_rdata <= smb_rdata_next;
    end
  end

  sequence cfg_read_s(logic [7:0] a);
    ce && cfg_req && !cfg_we && cfg_addr == a;
  endsequence

  sequence clear_write_s;
    ce && cfg_wr && cfg_addr == switch_debug_pkg::OFS_DEBUG_CTRL &&
      cfg_wdata[switch_debug_pkg::CLEAR_BIT] && !smb_wr;
  endsequence

  AST_MODE_READ: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_read_s(switch_debug_pkg::OFS_MODE_CLKBUF) |=>
      cfg_ack && cfg_rdata[31:21] == 11'h0 &&
      cfg_rdata[15:9] == 7'h0 && cfg_rdata[20] == $past(pd_reg))
    else $error("mode word read wrong");

  AST_REFCLK_GATE: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce |=> refclk_output_pair_en ==
      ($past(pd_reg) ? 4'h0 : $past(en_reg)))
    else $error("reference clock gate wrong");

  // three reset edges first, so the strap synchroniser holds a known level
  AST_STRAP_LOAD: assert property (@(posedge ref_clk) disable iff (1'b0)
    !resetn [*3] |=> pd_reg == $past(strap_s2))
    else $error("strap not loaded in reset");

  AST_PAIR_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
    !resetn ##1 (resetn && ce) |=> refclk_output_pair_en ==
      ($past(pd_reg) ? 4'h0 : 4'hF))
    else $error("clock pair enables not all on after reset");

  AST_CFG_NO_CLKBUF: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ce && cfg_wr && !smb_wr) |=> $stable(pd_reg) && $stable(en_reg) &&
      $stable(vendor_reg) && $stable(device_reg))
    else $error("config write changed a read-only field");

  AST_TRIG_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ce && cfg_wr && !smb_wr &&
      cfg_addr == switch_debug_pkg::OFS_DEBUG_CTRL) |=>
      trig_reg == $past(cfg_wdata[5:2]) &&
      port_reg == $past(cfg_wdata[1:0]))
    else $error("debug select not stored");

  AST_CLEAR_FLUSH: assert property (@(posedge ref_clk) disable iff (!resetn)
    clear_write_s |=> flush_reg && clear_reg ##1 (!ce || dbg.empty))
    else $error("clear did not flush buffer");

  AST_DATA_SMB_ONLY: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_read_s(switch_debug_pkg::OFS_DEBUG_DATA) |=>
      cfg_rdata == 32'h00000000)
    else $error("debug data visible to config read");

  AST_CAP_HDR: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_read_s(switch_debug_pkg::OFS_CAP_HDR) |=>
      cfg_rdata == 32'h0000C00D)
    else $error("capability header wrong");

  AST_SUBSYS_SMB: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ce && smb_wr && smb_addr == switch_debug_pkg::OFS_SUBSYS_ID) |=>
      {device_reg, vendor_reg} == $past(smb_wdata))
    else $error("subsystem codes not written by SMBus");
endmodule

// >>> core/training_capture_buffer.sv
`timescale 1ns/10ps
module training_capture_buffer #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  debug_capture_if.store dbg
);
  logic [31:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic armed_reg, armed_next;
  logic [3:0] last_reg, last_next;
  logic [switch_debug_pkg::STAMP_W-1:0] stamp_reg, stamp_next;
  logic wr_en, full, trig_valid, trig_hit;

  assign full = (wr_reg - rd_reg) == (AW+1)'(DEPTH);
  assign dbg.empty = wr_reg == rd_reg;
  // read side sees flops only; empty reads as zero
  assign dbg.data_out = dbg.empty ? 32'h00000000 : mem[rd_reg[AW-1:0]];
  assign trig_valid = dbg.trigger_sel >= switch_debug_pkg::TRIG_FIRST &&
    dbg.trigger_sel <= switch_debug_pkg::TRIG_LAST;
  assign trig_hit = trig_valid && dbg.link_state == dbg.trigger_sel;

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    armed_next = armed_reg;
    last_next = dbg.link_state;
    stamp_next = stamp_reg + 1'b1;
    wr_en = 1'b0;
    if (dbg.flush) begin
      wr_next = '0;
      rd_next = '0;
      armed_next = 1'b0;
    end else begin
      if (trig_hit)
        armed_next = 1'b1;
      // records the trigger entry, then every state change; drops when full
      if (!full && ((trig_hit && !armed_reg) ||
          (armed_reg && dbg.link_state != last_reg))) begin
        wr_en = 1'b1;
        wr_next = wr_reg + 1'b1;
      end
      if (dbg.pop && !dbg.empty)
        rd_next = rd_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      armed_reg <= 1'b0;
      last_reg <= 4'h0;
      stamp_reg <= '0;
    end else if (ce) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      armed_reg <= armed_next;
      last_reg <= last_next;
      stamp_reg <= stamp_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && wr_en)
      mem[wr_reg[AW-1:0]] <= {stamp_reg, dbg.link_state};
  end

  AST_FLUSH_EMPTY: assert property (@(posedge ref_clk) disable iff (!resetn)
    (dbg.flush && ce) |=> dbg.empty)
    else $error("buffer not empty after flush");

  AST_NO_OVERRUN: assert property (@(posedge ref_clk) disable iff (!resetn)
    (full && ce && !dbg.pop && !dbg.flush) |=> full && $stable(wr_reg))
    else $error("write pointer moved while buffer full");
endmodule

// >>> tb/smb_host_model.sv
`timescale 1ns/10ps
module smb_host_model #(
  parameter logic [31:0] LOAD_WORD = 32'h5A5AA5A5 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic autoload,
  output logic smb_req,
  output logic smb_we,
  output logic [7:0] smb_addr,
  output logic [31:0] smb_wdata,
  input wire logic smb_ack,
  input wire logic [31:0] smb_rdata,
  output logic load_done
);
  logic [31:0] load_rd;
  logic load_ok;
  // gap idles model a slow master; idle lines carry inverted values
  task automatic xfer(input logic we, input logic [7:0] a,
      input logic [31:0] wd, input int gap, output logic [31:0] rd,
      output logic ok);
    int i;
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1 {smb_req, smb_we, smb_addr, smb_wdata} = {1'b1, we, a, wd};
    @(posedge ref_clk);
    #1 {smb_req, smb_we, smb_addr, smb_wdata} = {1'b0, ~we, ~a, ~wd};
    for (i = 0; i < 8 && smb_ack !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    ok = (smb_ack === 1'b1);
    rd = smb_rdata;
  endtask
  initial begin
    {smb_req, smb_we, smb_addr, smb_wdata} = '0;
    forever begin
      load_done = 1'b0;
      @(posedge resetn);
      if (autoload) begin
        xfer(1'b1, switch_debug_pkg::OFS_SUBSYS_ID, LOAD_WORD, 0,
          load_rd, load_ok);
      end
      load_done = 1'b1;
      @(negedge resetn);
    end
  end
endmodule

// >>> tb/test_switch_mode_debug_subsystem_regs.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_switch_mode_debug_subsystem_regs;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic [31:0] mask;
  } row_t;
  localparam logic [15:0] VEN = 16'h5E01; // arbitrary value
  localparam logic [15:0] DEV = 16'h7A02; // arbitrary value
  localparam logic [31:0] LOADW = 32'h6B034C04; // arbitrary value
  localparam logic [7:0] M98 = switch_debug_pkg::OFS_MODE_CLKBUF;
  localparam logic [7:0] C9C = switch_debug_pkg::OFS_DEBUG_CTRL;
  localparam logic [7:0] DAC = switch_debug_pkg::OFS_DEBUG_DATA;
  localparam logic [7:0] IB4 = switch_debug_pkg::OFS_SUBSYS_ID;
  logic ref_clk, resetn, ce, strap, autoload, load_done;
  logic [8:0] mode_pins;
  logic [15:0] train;
  logic cfg_req, cfg_we, cfg_ack, smb_req, smb_we, smb_ack;
  logic [7:0] cfg_addr, smb_addr;
  logic [31:0] cfg_wdata, cfg_rdata, smb_wdata, smb_rdata, rd;
  logic [3:0] pair_en;
  int n_mismatch, samples_checked, i, t, p;
  row_t rows [11];
  row_t r;
  switch_mode_debug_subsystem_regs #(.VENDOR_DEFAULT(VEN),
    .DEVICE_DEFAULT(DEV)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .clock_buffer_powerdown_strap(strap), .op_mode_pins(mode_pins),
    .training_state_all(train), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .smb_req(smb_req), .smb_we(smb_we),
    .smb_addr(smb_addr), .smb_wdata(smb_wdata), .smb_ack(smb_ack),
    .smb_rdata(smb_rdata), .refclk_output_pair_en(pair_en));
  smb_host_model #(.LOAD_WORD(LOADW)) u_host (.ref_clk(ref_clk),
    .resetn(resetn), .autoload(autoload), .smb_req(smb_req),
    .smb_we(smb_we), .smb_addr(smb_addr), .smb_wdata(smb_wdata),
    .smb_ack(smb_ack), .smb_rdata(smb_rdata), .load_done(load_done));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic smb, input logic we, input logic [7:0] a,
      input logic [31:0] wd);
    logic ok;
    if (smb) begin
      u_host.xfer(we, a, wd, 1, rd, ok);
    end else begin
      @(posedge ref_clk);
      #1 {cfg_req, cfg_we, cfg_addr, cfg_wdata} = {1'b1, we, a, wd};
      @(posedge ref_clk);
      #1 {cfg_req, cfg_we, cfg_addr, cfg_wdata} = {1'b0, ~we, ~a, ~wd};
      for (i = 0; i < 8 && cfg_ack !== 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
      end
      ok = (cfg_ack === 1'b1);
      rd = cfg_rdata;
    end
    if (ok !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic rdchk(input logic smb, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m, input string nm);
    acc(smb, 1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask
  initial begin
    {resetn, ce, strap, autoload} = 4'h4;
    mode_pins = 9'h122;
    train = 16'h0000;
    {cfg_req, cfg_we, cfg_addr, cfg_wdata} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    rows[0] = '{2'h1, switch_debug_pkg::OFS_CAP_HDR, '1, 32'h0000C00D, '1};
    rows[1] = '{2'h1, C9C, 32'hFFFFFFBF, 32'h0000003F, '1};
    rows[2] = '{2'h0, 8'hA0, '0, '0, '1};
    rows[3] = '{2'h1, IB4, 32'h12345678, {DEV, VEN}, '1};
    rows[4] = '{2'h3, IB4, 32'hCAFE0123, 32'hCAFE0123, '1};
    rows[5] = '{2'h0, IB4, '0, 32'hCAFE0123, '1};
    rows[6] = '{2'h1, M98, '0, 32'h000F0000, 32'hFFFF0000};
    rows[7] = '{2'h3, M98, '1, 32'h001F0000, 32'hFFFF0000};
    rows[8] = '{2'h3, M98, 32'h000A0000, 32'h000A0000, 32'hFFFF0000};
    rows[9] = '{2'h1, C9C, '0, '0, '1};
    rows[10] = '{2'h3, C9C, 32'hFFFFFF97, 32'h00000017, '1};
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    rdchk(0, M98, 32'h000F0122, '1, "mode");
    `CHK("pair_en", 4'hF, pair_en)
    rdchk(0, IB4, {DEV, VEN}, '1, "ids");
    rdchk(0, C9C, 32'h0, '1, "dbgctl");
    foreach (rows[k]) begin
      r = rows[k];
      if (r.kind[0]) acc(r.kind[1], 1'b1, r.addr, r.wd);
      rdchk(r.kind[1], r.addr, r.exp, r.mask, "row");
    end
    `CHK("pair_en", 4'hA, pair_en)
    acc(1, 1, M98, 32'h001A0000);
    rdchk(1, M98, 32'h001A0000, 32'h001F0000, "clkbuf");
    `CHK("pair_en", 4'h0, pair_en)
    mode_pins = 9'h0AB;
    repeat (4) @(posedge ref_clk);
    rdchk(0, M98, 32'h000000AB, 32'hFFE0FFFF, "mode");
    // each code armed on port t % 4, so the four ports take turns; two entries must come back in order
    for (t = 1; t <= 11; t++) begin
      p = t % 4;
      acc(0, 1, C9C, 32'(64 + t * 4 + p));
      repeat (3) @(posedge ref_clk);
      #1 train = 16'(t) << (4 * p);
      repeat (3) @(posedge ref_clk);
      #1 train = 16'((t % 11) + 1) << (4 * p);
      repeat (3) @(posedge ref_clk);
      if (t == 5) rdchk(0, DAC, 32'h0, '1, "cfg_data");
      rdchk(1, DAC, 32'(t), 32'hF, "first");
      rdchk(1, DAC, 32'((t % 11) + 1), 32'hF, "second");
    end
    #1 train = 16'h2000;
    repeat (3) @(posedge ref_clk);
    acc(0, 1, C9C, 32'h0000006F);
    repeat (3) @(posedge ref_clk);
    rdchk(1, DAC, 32'h0, '1, "flushed");
    rdchk(0, C9C, 32'h0000006F, '1, "dbgctl");
    // sixteen entries fill the buffer; the later changes must be dropped
    for (t = 0; t < 20; t++) begin
      @(posedge ref_clk);
      #1 train = (t % 2) ? 16'h1000 : 16'hB000;
    end
    for (t = 0; t < 16; t++) begin
      rdchk(1, DAC, (t % 2) ? 32'h1 : 32'hB, 32'hF, "fill");
    end
    rdchk(1, DAC, 32'h0, '1, "drained");
    // a request while the clock enable is low must leave no trace
    @(posedge ref_clk);
    #1 ce = 1'b0;
    {cfg_req, cfg_we, cfg_addr, cfg_wdata} = {1'b1, 1'b1, C9C, 32'h0};
    @(posedge ref_clk);
    #1 {cfg_req, cfg_we} = 2'h0;
    ce = 1'b1;
    `CHK("frozen_ack", 1'b0, cfg_ack)
    rdchk(0, C9C, 32'h0000006F, '1, "frozen");
    @(posedge ref_clk);
    #1 {resetn, strap, autoload} = 3'h3;
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    for (t = 0; t < 50 && load_done !== 1'b1; t++) @(posedge ref_clk);
    if (load_done !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    `CHK("pair_en", 4'h0, pair_en)
    rdchk(0, M98, 32'h001F00AB, '1, "strap");
    rdchk(0, IB4, LOADW, '1, "loaded");
    give_verdict();
  end
endmodule
